/* src/mclk_map.svh */
`ifndef MCLK_MAP_SVH
`define MCLK_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define MCLK_IDX_SRC_SEL      6'h00
`define MCLK_IDX_PRESCALE     6'h01
`define MCLK_IDX_LOCK         6'h02
`define MCLK_IDX_STATUS       6'h03
`define MCLK_IDX_FAST_CTRL    6'h10
`define MCLK_IDX_FAST_CENTER  6'h11
`define MCLK_IDX_FAST_SLOPE   6'h12
`define MCLK_IDX_SLOW_CTRL    6'h18

// Reset values.
`define MCLK_RST_SRC_SEL      2'h0
`define MCLK_RST_DIVISION_RATIO_FIELD         4'h8
`define MCLK_RST_PEN          1'b1
`define MCLK_RST_RATIO        7'h06

// Field positions.
`define MCLK_PEN_BIT          0
`define MCLK_DIVISION_RATIO_FIELD_LSB         1
`define MCLK_DIVISION_RATIO_FIELD_MSB         4
`define MCLK_LOCK_BIT         0
`define MCLK_KEEP_RUN_BIT     1
`define MCLK_ST_EXT_BIT       7
`define MCLK_ST_SLOW_BIT      5
`define MCLK_ST_FAST_BIT      4
`define MCLK_ST_SWITCH_BIT    0
`define MCLK_SLOPE_LOCK_BIT   7

// Timing counts, in source clock edges or retired instructions.
`define MCLK_OSC_GATE_EDGES   4
`define MCLK_EXT_START_EDGES  2
`define MCLK_GUARD_INSTRS     3'h4

`endif

/* src/mclk_pkg.sv */
package mclk_pkg;

  // Main clock source codes as held in the source select field.
  typedef enum logic [1:0] {
    MCLK_SRC_FAST = 2'h0,
    MCLK_SRC_SLOW = 2'h1,
    MCLK_SRC_RSVD = 2'h2,
    MCLK_SRC_EXT  = 2'h3
  } mclk_src_t;

  // Source switch sequencer, Gray coded along idle, pending, commit.
  typedef enum logic [1:0] {
    MCLK_SW_IDLE   = 2'b00,
    MCLK_SW_PEND   = 2'b01,
    MCLK_SW_COMMIT = 2'b11
  } mclk_sw_state_t;

endpackage

/* src/mclk_osc_gate.sv */
`timescale 1ns/1ps

module mclk_osc_gate #(
  parameter int unsigned START_EDGES = 4
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Oscillator side, asynchronous
  input  wire logic osc_clk,
  input  wire logic analog_ready,
  // Control
  input  wire logic request,
  input  wire logic skip_analog,
  // Results
  output logic      osc_level,
  output logic      osc_tick,
  output logic      gate_open
);

  logic       clk_meta_reg;
  logic       clk_sync_reg;
  logic       clk_prev_reg;
  logic       rdy_meta_reg;
  logic       rdy_sync_reg;
  logic [2:0] edge_cnt_reg;

  // Two-flop synchronisers; the first stage feeds only the second, and the edge detect also uses the clk_prev_reg stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_meta_reg <= 1'b0;
      clk_sync_reg <= 1'b0;
      clk_prev_reg <= 1'b0;
      rdy_meta_reg <= 1'b0;
      rdy_sync_reg <= 1'b0;
    end else begin
      clk_meta_reg <= osc_clk;
      clk_sync_reg <= clk_meta_reg;
      clk_prev_reg <= clk_sync_reg;
      rdy_meta_reg <= analog_ready;
      rdy_sync_reg <= rdy_meta_reg;
    end
  end

  assign osc_level = clk_sync_reg;
  assign osc_tick  = clk_sync_reg & ~clk_prev_reg;

  // The gate opens after the start edges are seen; dropping the request closes it at once.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_cnt_reg <= 3'h0;
      gate_open    <= 1'b0;
    end else if (!request) begin
      edge_cnt_reg <= 3'h0;
      gate_open    <= 1'b0;
    end else if (!gate_open && (rdy_sync_reg || skip_analog) && osc_tick) begin
      if (edge_cnt_reg == 3'(START_EDGES - 1)) begin
        gate_open <= 1'b1;
      end
      edge_cnt_reg <= edge_cnt_reg + 3'h1;
    end
  end

endmodule // mclk_osc_gate

/* src/mclk_ctrl.sv */
`timescale 1ns/1ps
`include "mclk_map.svh"

// Functional notes
// - A request for the external clock turns its pin into the clock input.
// - External clock counts two edges after a request before it is usable.
// - Guarded writes land only within four instructions after the key is written.
// - Guarded writes outside the window complete but change nothing.
// - All writable registers of this block are guarded by the same key.
// - Source codes: 0 fast RC, 1 slow RC, 3 external, 2 reserved.
// - Ratio codes 0-5 divide 2..64, codes 8-C divide 6,10,12,24,48.
// - Prescaler off passes the main clock undivided whatever the ratio.
// - The ratio may be rewritten while running and takes effect.
// - Lock blocks writes to source, prescaler and active source trims.
// - Once locked, the lock register ignores all access until reset.
// - Status bit 7 shows the external clock has started.
// - Oscillator stable bits show only while that source is requested.
// - Status bit 0 is high while a source switch is pending.
// - Keep-running bit holds an oscillator powered in every mode.
// - An unrequested oscillator delivers no clock even if kept running.
// - Internal oscillator gates open on the fourth source edge after request; keep-running skips analog start-up.
// - A pending switch blocks any further source change until it completes.
// - After reset: fast RC, prescaler on, divide by six.
module mclk_ctrl (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Processor change guard
  input  wire logic        cpu_key_written,
  input  wire logic        cpu_instr_retired,
  // Clock requests and sleep state
  input  wire logic [2:0]  periph_clk_req,
  input  wire logic        sleep_standby,
  // Oscillators and external pin
  input  wire logic        fast_internal_rc,
  input  wire logic        slow_internal_rc,
  input  wire logic        ext_pin_clock_source,
  input  wire logic [1:0]  osc_analog_ready,
  output logic      [1:0]  osc_power_on,
  output logic             ext_pin_as_clock,
  // Fuse values and trims
  input  wire logic [5:0]  fuse_center_trim,
  input  wire logic [3:0]  fuse_slope_trim,
  input  wire logic        fuse_trim_lock,
  output logic      [5:0]  center_trim_field,
  output logic      [3:0]  slope_trim_field,
  // Clock outputs
  output logic             main_clk,
  output logic             main_tick,
  output logic             per_clk,
  output logic             per_tick,
  output logic      [1:0]  main_source_active
);

  logic [1:0]               src_sel_reg;
  logic [3:0]               division_ratio_field_reg;
  logic                     pen_reg;
  logic                     lock_reg;
  logic                     fast_keep_reg;
  logic                     slow_keep_reg;
  logic                     trim_loaded_reg;
  logic [2:0]               guard_cnt_reg;
  logic [1:0]               active_src_reg;
  mclk_pkg::mclk_sw_state_t sw_state_reg;
  logic [6:0]               ratio_act_reg;
  logic                     pen_act_reg;
  logic [6:0]               div_cnt_reg;
  logic                     per_phase_reg;
  logic [2:0]               src_req;
  logic [2:0]               osc_level;
  logic [2:0]               osc_tick;
  logic [2:0]               gate_open;
  logic [2:0]               osc_in;
  logic [2:0]               osc_rdy;
  logic [2:0]               skip_analog;
  logic                     wr_en;
  logic                     guard_open;
  logic                     sw_busy;
  logic                     trim_blocked;
  logic [1:0]               act_i;
  logic [1:0]               new_i;
  logic                     main_level_raw;
  logic                     main_tick_raw;
  logic [6:0]               eff_ratio;
  logic                     div_wrap;
  logic [7:0]               status_byte;
  logic [7:0]               rd_byte;
  logic                     addr_hit_any;

  // Word decode shared by reads, writes and the error answer.
  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return a == {idx, 2'b00};
  endfunction

  // Source code to gate index: fast 0, slow 1, external 2.
  function automatic logic [1:0] src_idx(input logic [1:0] s);
    if (s == mclk_pkg::MCLK_SRC_SLOW) return 2'd1;
    else if (s == mclk_pkg::MCLK_SRC_EXT) return 2'd2;
    else return 2'd0;
  endfunction

  // Division ratio decode; reserved codes fall back to the smallest ratio.
  function automatic logic [6:0] ratio_of(input logic [3:0] code);
    case (code)
      4'h0: return 7'd2;
      4'h1: return 7'd4;
      4'h2: return 7'd8;
      4'h3: return 7'd16;
      4'h4: return 7'd32;
      4'h5: return 7'd64;
      4'h8: return 7'd6;
      4'h9: return 7'd10;
      4'ha: return 7'd12;
      4'hb: return 7'd24;
      4'hc: return 7'd48;
      default: return 7'd2;
    endcase
  endfunction

  // Bus handshake: zero wait states, error only for an unmapped word.
  assign wr_en        = psel & penable & pwrite;
  assign guard_open   = guard_cnt_reg != 3'h0;
  assign pready       = 1'b1;
  assign addr_hit_any = hit(paddr, `MCLK_IDX_SRC_SEL) | hit(paddr, `MCLK_IDX_PRESCALE) |
                        hit(paddr, `MCLK_IDX_LOCK) | hit(paddr, `MCLK_IDX_STATUS) |
                        hit(paddr, `MCLK_IDX_FAST_CTRL) | hit(paddr, `MCLK_IDX_FAST_CENTER) |
                        hit(paddr, `MCLK_IDX_FAST_SLOPE) | hit(paddr, `MCLK_IDX_SLOW_CTRL);
  assign pslverr      = psel & penable & ~addr_hit_any;

  // Window counter: the key loads it, each retired instruction counts it down.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      guard_cnt_reg <= 3'h0;
    end else if (cpu_key_written) begin
      guard_cnt_reg <= `MCLK_GUARD_INSTRS;
    end else if (cpu_instr_retired && guard_open) begin
      guard_cnt_reg <= guard_cnt_reg - 3'h1;
    end
  end

  // A switch in flight freezes the source field so the sequencer never chases a moving target.
  assign sw_busy      = (src_sel_reg != active_src_reg) || (sw_state_reg != mclk_pkg::MCLK_SW_IDLE);
  assign trim_blocked = fuse_trim_lock | (lock_reg & (act_i == 2'd0));

  // Source select and prescaler writes; every one needs the open window.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_sel_reg <= `MCLK_RST_SRC_SEL;
      division_ratio_field_reg    <= `MCLK_RST_DIVISION_RATIO_FIELD;
      pen_reg     <= `MCLK_RST_PEN;
    end else if (wr_en && guard_open && !lock_reg) begin
      if (hit(paddr, `MCLK_IDX_SRC_SEL)) begin
        if (!sw_busy && pwdata[1:0] != mclk_pkg::MCLK_SRC_RSVD) begin
          src_sel_reg <= pwdata[1:0];
        end
      end else if (hit(paddr, `MCLK_IDX_PRESCALE)) begin
        division_ratio_field_reg <= pwdata[`MCLK_DIVISION_RATIO_FIELD_MSB:`MCLK_DIVISION_RATIO_FIELD_LSB];
        pen_reg  <= pwdata[`MCLK_PEN_BIT];
      end
    end
  end

  // Lock bit: once set it ignores every later write until reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
    end else if (wr_en && guard_open && !lock_reg && hit(paddr, `MCLK_IDX_LOCK)) begin
      lock_reg <= pwdata[`MCLK_LOCK_BIT];
    end
  end

  // Keep-running bits of both internal oscillators.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_keep_reg <= 1'b0;
      slow_keep_reg <= 1'b0;
    end else if (wr_en && guard_open) begin
      if (hit(paddr, `MCLK_IDX_FAST_CTRL)) begin
        fast_keep_reg <= pwdata[`MCLK_KEEP_RUN_BIT];
      end else if (hit(paddr, `MCLK_IDX_SLOW_CTRL)) begin
        slow_keep_reg <= pwdata[`MCLK_KEEP_RUN_BIT];
      end
    end
  end

  // Trims come from fuses on the first edge after reset; fuse pins are not reset constants.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_loaded_reg   <= 1'b0;
      center_trim_field <= 6'h00;
      slope_trim_field  <= 4'h0;
    end else if (!trim_loaded_reg) begin
      trim_loaded_reg   <= 1'b1;
      center_trim_field <= fuse_center_trim;
      slope_trim_field  <= fuse_slope_trim;
    end else if (wr_en && guard_open && !trim_blocked) begin
      if (hit(paddr, `MCLK_IDX_FAST_CENTER)) begin
        center_trim_field <= pwdata[5:0];
      end else if (hit(paddr, `MCLK_IDX_FAST_SLOPE)) begin
        slope_trim_field <= pwdata[3:0];
      end
    end
  end

  // Requests: peripherals, plus the running main source and a pending target while awake.
  assign act_i = src_idx(active_src_reg);
  assign new_i = src_idx(src_sel_reg);
  always_comb begin
    src_req = periph_clk_req;
    if (!sleep_standby) begin
      src_req[act_i] = 1'b1;
      if (sw_busy) begin
        src_req[new_i] = 1'b1;
      end
    end
  end

  // Power and pin configuration for the three sources.
  assign osc_power_on[0]  = src_req[0] | fast_keep_reg;
  assign osc_power_on[1]  = src_req[1] | slow_keep_reg;
  assign ext_pin_as_clock = src_req[2];

  // Start-up gates; the pin clock has no analog phase.
  assign osc_in      = {ext_pin_clock_source, slow_internal_rc, fast_internal_rc};
  assign osc_rdy     = {1'b1, osc_analog_ready};
  assign skip_analog = {1'b1, slow_keep_reg, fast_keep_reg};
  generate
    for (genvar g = 0; g < 3; g++) begin : g_gate
      mclk_osc_gate #(
        .START_EDGES ((g == 2) ? `MCLK_EXT_START_EDGES : `MCLK_OSC_GATE_EDGES)
      ) u_gate (
        .pclk         (pclk),
        .presetn      (presetn),
        .osc_clk      (osc_in[g]),
        .analog_ready (osc_rdy[g]),
        .request      (src_req[g]),
        .skip_analog  (skip_analog[g]),
        .osc_level    (osc_level[g]),
        .osc_tick     (osc_tick[g]),
        .gate_open    (gate_open[g])
      );
    end
  endgenerate

  // Switch sequencer: wait for the target gate, then commit on its rising edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_state_reg   <= mclk_pkg::MCLK_SW_IDLE;
      active_src_reg <= `MCLK_RST_SRC_SEL;
    end else begin
      case (sw_state_reg)
        mclk_pkg::MCLK_SW_IDLE: begin
          if (src_sel_reg != active_src_reg) begin
            sw_state_reg <= mclk_pkg::MCLK_SW_PEND;
          end
        end
        mclk_pkg::MCLK_SW_PEND: begin
          if (gate_open[new_i]) begin
            sw_state_reg <= mclk_pkg::MCLK_SW_COMMIT;
          end
        end
        mclk_pkg::MCLK_SW_COMMIT: begin
          if (osc_tick[new_i] && gate_open[new_i]) begin
            active_src_reg <= src_sel_reg;
            sw_state_reg   <= mclk_pkg::MCLK_SW_IDLE;
          end
        end
        default: sw_state_reg <= mclk_pkg::MCLK_SW_IDLE;
      endcase
    end
  end

  // Main clock is the gated level of the active source only.
  assign main_level_raw = osc_level[act_i] & gate_open[act_i];
  assign main_tick_raw  = osc_tick[act_i] & gate_open[act_i];
  assign eff_ratio      = pen_act_reg ? ratio_act_reg : 7'd1;
  assign div_wrap       = div_cnt_reg >= (eff_ratio - 7'd1);

  // Divider; new ratio and enable load only at a period boundary so no pulse is cut short.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_reg   <= 7'h00;
      ratio_act_reg <= `MCLK_RST_RATIO;
      pen_act_reg   <= `MCLK_RST_PEN;
      per_phase_reg <= 1'b0;
    end else if (main_tick_raw) begin
      if (div_wrap) begin
        div_cnt_reg   <= 7'h00;
        ratio_act_reg <= ratio_of(division_ratio_field_reg);
        pen_act_reg   <= pen_reg;
        per_phase_reg <= 1'b1;
      end else begin
        div_cnt_reg   <= div_cnt_reg + 7'h01;
        per_phase_reg <= (div_cnt_reg + 7'h01) < {1'b0, eff_ratio[6:1]};
      end
    end
  end

  // Registered clock outputs; bypass copies the main level straight through.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      main_clk           <= 1'b0;
      main_tick          <= 1'b0;
      per_clk            <= 1'b0;
      per_tick           <= 1'b0;
      main_source_active <= `MCLK_RST_SRC_SEL;
    end else begin
      main_clk           <= main_level_raw;
      main_tick          <= main_tick_raw;
      per_clk            <= pen_act_reg ? per_phase_reg : main_level_raw;
      per_tick           <= main_tick_raw & div_wrap;
      main_source_active <= active_src_reg;
    end
  end

  // Status: stable bits come from gates that close whenever the request drops.
  always_comb begin
    status_byte                      = 8'h00;
    status_byte[`MCLK_ST_EXT_BIT]    = gate_open[2];
    status_byte[`MCLK_ST_SLOW_BIT]   = gate_open[1];
    status_byte[`MCLK_ST_FAST_BIT]   = gate_open[0];
    status_byte[`MCLK_ST_SWITCH_BIT] = sw_busy;
  end

  // Read decode; the lock register always reads as zero, locked or not.
  always_comb begin
    rd_byte = 8'h00;
    if (hit(paddr, `MCLK_IDX_SRC_SEL)) begin
      rd_byte = {6'h00, src_sel_reg};
    end else if (hit(paddr, `MCLK_IDX_PRESCALE)) begin
      rd_byte = {3'h0, division_ratio_field_reg, pen_reg};
    end else if (hit(paddr, `MCLK_IDX_LOCK)) begin
      rd_byte = 8'h00;
    end else if (hit(paddr, `MCLK_IDX_STATUS)) begin
      rd_byte = status_byte;
    end else if (hit(paddr, `MCLK_IDX_FAST_CTRL)) begin
      rd_byte = {6'h00, fast_keep_reg, 1'b0};
    end else if (hit(paddr, `MCLK_IDX_FAST_CENTER)) begin
      rd_byte = {2'h0, center_trim_field};
    end else if (hit(paddr, `MCLK_IDX_FAST_SLOPE)) begin
      rd_byte = {fuse_trim_lock, 3'h0, slope_trim_field};
    end else if (hit(paddr, `MCLK_IDX_SLOW_CTRL)) begin
      rd_byte = {6'h00, slow_keep_reg, 1'b0};
    end
  end

  // Read data is captured in the setup phase and held through the access phase.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata <= {24'h00_0000, rd_byte};
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_target_ready;
    sw_state_reg == mclk_pkg::MCLK_SW_PEND && gate_open[new_i];
  endsequence

  sequence s_guarded_src_write;
    wr_en && hit(paddr, `MCLK_IDX_SRC_SEL);
  endsequence

  a_guard_closed_write: assert property (
    s_guarded_src_write ##0 !guard_open |=> $stable(src_sel_reg))
    else $error("Source select changed with the guard window closed.");

  a_guard_window_len: assert property (
    cpu_key_written |=> guard_cnt_reg == 3'h4)
    else $error("Guard window not loaded with four instructions.");

  a_lock_sticky: assert property (
    lock_reg |=> lock_reg [*8])
    else $error("Lock bit cleared without reset.");

  a_lock_blocks_div: assert property (
    lock_reg |=> $stable(division_ratio_field_reg) && $stable(pen_reg) && $stable(src_sel_reg))
    else $error("Locked main clock settings changed.");

  a_switch_commit: assert property (
    s_target_ready ##1 (osc_tick[new_i] && gate_open[new_i])
      |=> sw_state_reg == mclk_pkg::MCLK_SW_IDLE && active_src_reg == $past(src_sel_reg))
    else $error("Switch did not complete on the new source edge.");

  a_unrequested_status: assert property (
    !src_req[0] |=> !status_byte[`MCLK_ST_FAST_BIT])
    else $error("Fast oscillator reports stable without a request.");

  a_ext_start: assert property (
    $rose(gate_open[2]) |-> $past(src_req[2]) && $past(osc_tick[2]))
    else $error("External gate opened without a requested edge.");

  a_bypass_undivided: assert property (
    !pen_act_reg && main_tick_raw |=> per_tick)
    else $error("Bypassed prescaler dropped a main clock edge.");

  a_src_reserved: assert property (
    src_sel_reg != mclk_pkg::MCLK_SRC_RSVD)
    else $error("Reserved source code stored.");

endmodule // mclk_ctrl

/* test/test_main_clock_controller.sv */
`timescale 1ns/1ps
`include "mclk_map.svh"

module test_main_clock_controller;
  // Bench side of every port of the controller except the fuse inputs, which are tied to constants.
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, key, ret;
  logic        fast, slow, ext, ext_run, pin_clk, mclk, mtick, pclk_div, ptick, stby;
  logic [7:0]  paddr, r;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  req;
  logic [1:0]  ready, pwr, act;
  logic [5:0]  ctrim;
  logic [3:0]  strim;
  int          miscompares = 0;
  int          check_count = 0;
  int          cycles = 0;
  // Cycles, per_clk high cycles and main_clk high cycles over one measured period.
  int          cy, hi, mh;
  // Ratio cases, the last one a reserved code: prescaler byte written and main ticks per peripheral period.
  logic [7:0]  row_wr [13] = '{8'h10, 8'h01, 8'h03, 8'h05, 8'h07, 8'h09, 8'h0b,
                               8'h11, 8'h13, 8'h15, 8'h17, 8'h19, 8'h0d};
  logic [7:0]  row_div [13] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40,
                                8'h06, 8'h0a, 8'h0c, 8'h18, 8'h30, 8'h02};

  mclk_ctrl i_mclk_ctrl (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cpu_key_written(key), .cpu_instr_retired(ret), .periph_clk_req(req),
    .sleep_standby(stby), .fast_internal_rc(fast), .slow_internal_rc(slow),
    .ext_pin_clock_source(ext), .osc_analog_ready(ready), .osc_power_on(pwr),
    .ext_pin_as_clock(pin_clk), .fuse_center_trim(6'h2a), .fuse_slope_trim(4'h5),
    .fuse_trim_lock(1'b0), .center_trim_field(ctrim), .slope_trim_field(strim),
    .main_clk(mclk), .main_tick(mtick), .per_clk(pclk_div), .per_tick(ptick),
    .main_source_active(act)
  );

  // Sources run slower than the bus clock because the controller samples them.
  always #2.5 pclk = ~pclk;
  always #10 fast = ~fast;
  always #40 slow = ~slow;
  always #15 ext = ext_run ? ~ext : 1'b0;

  // Hang guard; the whole run needs well under half of this.
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer; the leading edge keeps back-to-back calls from double driving.
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdr(input logic [5:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  task automatic pulse_key();
    @(posedge pclk);
    key <= 1'b1;
    @(posedge pclk);
    key <= 1'b0;
  endtask

  task automatic gw(input logic [5:0] idx, input logic [7:0] d);
    pulse_key();
    apb(1'b1, idx, d);
  endtask

  task automatic retire(input int k);
    repeat (k) begin
      @(posedge pclk);
      ret <= 1'b1;
      @(posedge pclk);
      ret <= 1'b0;
    end
  endtask

  // Two periods are skipped because a new ratio waits for a period boundary.
  // Both clock levels must spend exactly half of a settled period high on the fast source.
  task automatic measure();
    r = 8'h00;
    cy = 0;
    hi = 0;
    mh = 0;
    repeat (2) do @(posedge pclk); while (ptick !== 1'b1);
    do begin
      @(posedge pclk);
      r = r + {7'h0, mtick};
      cy++;
      hi += int'(pclk_div);
      mh += int'(mclk);
    end while (ptick !== 1'b1);
    chk(32'(2 * hi), 32'(cy));
    chk(32'(2 * mh), 32'(cy));
  endtask

  task automatic wait_act(input logic [1:0] s);
    repeat (2000) begin
      @(posedge pclk);
      if (act === s) break;
    end
    chk({30'h0, act}, {30'h0, s});
  endtask

  task automatic reset_checks();
    presetn <= 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdr(`MCLK_IDX_SRC_SEL, 8'h00);
    rdr(`MCLK_IDX_PRESCALE, 8'h11);
    rdr(`MCLK_IDX_LOCK, 8'h00);
    rdr(`MCLK_IDX_FAST_CENTER, 8'h2a);
    rdr(`MCLK_IDX_FAST_SLOPE, 8'h05);
    chk({28'h0, strim}, 32'h5);
    measure();
    chk({24'h0, r}, 32'h6);
    $display("test reset done");
  endtask

  // Main sequence: ratio rows first, then the awkward cases.
  initial begin
    {pclk, fast, slow, ext, ext_run, psel, penable, pwrite, key, ret, stby} = '0;
    {paddr, pwdata, req} = '0;
    ready = 2'h3;
    presetn = 1'b0;
    reset_checks();
    for (int i = 0; i < 13; i++) begin
      gw(`MCLK_IDX_PRESCALE, row_wr[i]);
      rdr(`MCLK_IDX_PRESCALE, row_wr[i]);
      measure();
      chk({24'h0, r}, {24'h0, row_div[i]});
    end
    $display("test ratio rows done");
    // The last row left the window open; four retired instructions close it.
    retire(4);
    apb(1'b1, `MCLK_IDX_PRESCALE, 8'h11);
    rdr(`MCLK_IDX_PRESCALE, 8'h0d);
    pulse_key();
    retire(4);
    apb(1'b1, `MCLK_IDX_PRESCALE, 8'h11);
    rdr(`MCLK_IDX_PRESCALE, 8'h0d);
    pulse_key();
    retire(3);
    apb(1'b1, `MCLK_IDX_PRESCALE, 8'h03);
    apb(1'b1, `MCLK_IDX_PRESCALE, 8'h05);
    rdr(`MCLK_IDX_PRESCALE, 8'h05);
    retire(1);
    apb(1'b1, `MCLK_IDX_SRC_SEL, 8'h01);
    rdr(`MCLK_IDX_SRC_SEL, 8'h00);
    apb(1'b0, 6'h05, 8'h00);
    chk({31'h0, err}, 32'h1);
    $display("test guard done");
    gw(`MCLK_IDX_SRC_SEL, 8'h01);
    apb(1'b0, `MCLK_IDX_STATUS, 8'h00);
    chk({31'h0, rd[0]}, 32'h1);
    wait_act(2'h1);
    rdr(`MCLK_IDX_STATUS, 8'h20);
    gw(`MCLK_IDX_SRC_SEL, 8'h02);
    rdr(`MCLK_IDX_SRC_SEL, 8'h01);
    gw(`MCLK_IDX_FAST_CTRL, 8'h02);
    @(posedge pclk);
    chk({31'h0, pwr[0]}, 32'h1);
    rdr(`MCLK_IDX_STATUS, 8'h20);
    // The fast source never reports analog start-up, so only keep-running opens it.
    ready <= 2'h2;
    req <= 3'h1;
    repeat (60) @(posedge pclk);
    rdr(`MCLK_IDX_STATUS, 8'h30);
    req <= 3'h4;
    ready <= 2'h3;
    repeat (2) @(posedge pclk);
    chk({31'h0, pin_clk}, 32'h1);
    rdr(`MCLK_IDX_STATUS, 8'h20);
    gw(`MCLK_IDX_SRC_SEL, 8'h03);
    gw(`MCLK_IDX_SRC_SEL, 8'h00);
    rdr(`MCLK_IDX_SRC_SEL, 8'h03);
    rdr(`MCLK_IDX_STATUS, 8'h21);
    ext_run <= 1'b1;
    wait_act(2'h3);
    rdr(`MCLK_IDX_STATUS, 8'h80);
    // In standby with no requests only the kept fast oscillator stays powered.
    stby <= 1'b1;
    req <= 3'h0;
    repeat (2) @(posedge pclk);
    chk({30'h0, pwr}, 32'h1);
    chk({31'h0, pin_clk}, 32'h0);
    stby <= 1'b0;
    req <= 3'h4;
    $display("test source switch done");
    gw(`MCLK_IDX_LOCK, 8'h01);
    gw(`MCLK_IDX_PRESCALE, 8'h01);
    rdr(`MCLK_IDX_PRESCALE, 8'h05);
    gw(`MCLK_IDX_SRC_SEL, 8'h00);
    rdr(`MCLK_IDX_SRC_SEL, 8'h03);
    rdr(`MCLK_IDX_LOCK, 8'h00);
    req <= 3'h0;
    reset_checks();
    gw(`MCLK_IDX_PRESCALE, 8'h03);
    rdr(`MCLK_IDX_PRESCALE, 8'h03);
    gw(`MCLK_IDX_LOCK, 8'h01);
    gw(`MCLK_IDX_FAST_CENTER, 8'h15);
    rdr(`MCLK_IDX_FAST_CENTER, 8'h2a);
    chk({26'h0, ctrim}, 32'h2a);
    $display("test lock done");
    stop_test();
  end
endmodule // test_main_clock_controller
